// ===== rtl/xmalu_core.sv
// Execute stage for the extended data-memory instruction group.
// Assumes memory read data is valid combinationally in the issue cycle and
// the fetch unit holds off issue while busy is high.
//
// Behaviour
// - rotate left, bit seven into bit zero
// - rotate left through carry, only carry changes
// - rotate right, bit zero into bit seven
// - rotate right through carry, only carry changes
// - register-target variants leave memory unwritten
// - subtract with borrow, six flags, optional memory
// - carry cleared on negative, set otherwise
// - plain subtract, register or memory target
// - taken skip lasts three cycles
// - decrement memory, skip when zero
// - decrement into register, skip when zero
// - increment memory, skip on wrap to zero
// - increment into register, skip when zero
// - set byte writes all ones
// - set bit forces one selected bit
// - skip when selected bit is set
// - skip if nonzero, byte rewritten unchanged
// - skip if zero, byte rewritten unchanged
// - nibble swap, register variant keeps memory
// - full address reaches any memory section
`timescale 1ns/10ps
module xmalu_core
  import xmalu_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // Instruction issue
  input  wire logic               issue_valid,
  input  wire xmalu_instr_s       issue,
  output logic                    busy,
  // Data memory
  output logic      [ADDR_W-1:0]  mem_addr,
  input  wire logic [DATA_W-1:0]  mem_rdata,
  output logic                    mem_we,
  output logic      [DATA_W-1:0]  mem_wdata,
  // Architectural state
  output logic      [DATA_W-1:0]  working_register,
  output logic      [FLG_W-1:0]   status_flags,
  // Sequencing
  output logic                    skip_next,
  output logic                    dummy_cycle
);

  xmalu_result_s    res;
  xmalu_state_e     state_r;
  logic [CYC_CNT_W-1:0] cyc_r;
  logic [DATA_W-1:0] wreg_r;
  logic [FLG_W-1:0]  flags_r;
  logic              mem_we_r;
  logic [DATA_W-1:0] mem_wdata_r;
  logic [ADDR_W-1:0] mem_waddr_r;
  logic              skip_r;
  logic [DATA_W-1:0] sub_diff;
  logic [FLG_W-1:0]  sub_flags;
  logic              sub_borrow;
  logic              sub_chain;
  logic [DATA_W-1:0] bit_mask;
  logic [DATA_W-1:0] dec_val;
  logic [DATA_W-1:0] inc_val;
  logic              go;
  logic              carry;

  assign go    = issue_valid && (state_r == XMALU_ST_IDLE);
  assign carry = flags_r[FLG_C];

  // One-hot bit select for the bit-addressed operations
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_mask
      assign bit_mask[gi] = (issue.bit_sel == BIT_SEL_W'(gi));
    end
  endgenerate

  assign dec_val = mem_rdata - ONE_BYTE;
  assign inc_val = mem_rdata + ONE_BYTE;

  // Borrow-in is the inverted carry only for the borrow forms
  always_comb begin
    sub_chain  = (issue.op == XMALU_SUBTRACT_BORROW_TO_WREG) ||
                 (issue.op == XMALU_SUBTRACT_BORROW_TO_MEM);
    sub_borrow = sub_chain & ~carry;
  end

  xmalu_subtract u_sub (
    .minuend    (wreg_r),
    .subtrahend (mem_rdata),
    .borrow_in  (sub_borrow),
    .zero_in    (flags_r[FLG_Z]),
    .chain      (sub_chain),
    .diff       (sub_diff),
    .flags      (sub_flags)
  );

  // Operation decode
  always_comb begin
    res           = '0;
    res.flag_mask = '0;
    res.flag_val  = '0;
    case (issue.op)
      XMALU_ROTATE_LEFT_MEM: begin
        res.value  = {mem_rdata[6:0], mem_rdata[7]};
        res.to_mem = 1'b1;
      end
      XMALU_ROTATE_LEFT_TO_WREG: begin
        res.value   = {mem_rdata[6:0], mem_rdata[7]};
        res.to_wreg = 1'b1;
      end
      XMALU_ROTATE_LEFT_THRU_CARRY, XMALU_ROTATE_LEFT_THRU_CARRY_TO_WREG: begin
        res.value           = {mem_rdata[6:0], carry};
        res.to_mem          = (issue.op == XMALU_ROTATE_LEFT_THRU_CARRY);
        res.to_wreg         = ~res.to_mem;
        res.flag_mask[FLG_C] = 1'b1;
        res.flag_val[FLG_C]  = mem_rdata[7];
      end
      XMALU_ROTATE_RIGHT_MEM: begin
        res.value  = {mem_rdata[0], mem_rdata[7:1]};
        res.to_mem = 1'b1;
      end
      XMALU_ROTATE_RIGHT_TO_WREG: begin
        res.value   = {mem_rdata[0], mem_rdata[7:1]};
        res.to_wreg = 1'b1;
      end
      XMALU_ROTATE_RIGHT_THRU_CARRY, XMALU_ROTATE_RIGHT_THRU_CARRY_TO_WREG: begin
        res.value           = {carry, mem_rdata[7:1]};
        res.to_mem          = (issue.op == XMALU_ROTATE_RIGHT_THRU_CARRY);
        res.to_wreg         = ~res.to_mem;
        res.flag_mask[FLG_C] = 1'b1;
        res.flag_val[FLG_C]  = mem_rdata[0];
      end
      XMALU_SUBTRACT_BORROW_TO_WREG, XMALU_SUBTRACT_TO_WREG: begin
        res.value     = sub_diff;
        res.to_wreg   = 1'b1;
        res.flag_mask = '1;
        res.flag_val  = sub_flags;
      end
      XMALU_SUBTRACT_BORROW_TO_MEM, XMALU_SUBTRACT_TO_MEM: begin
        res.value     = sub_diff;
        res.to_mem    = 1'b1;
        res.flag_mask = '1;
        res.flag_val  = sub_flags;
      end
      XMALU_DEC_SKIP_ZERO: begin
        res.value  = dec_val;
        res.to_mem = 1'b1;
        res.skip   = (dec_val == ZERO_BYTE);
      end
      XMALU_DEC_TO_WREG_SKIP_ZERO: begin
        res.value   = dec_val;
        res.to_wreg = 1'b1;
        res.skip    = (dec_val == ZERO_BYTE);
      end
      XMALU_INC_SKIP_ZERO: begin
        res.value  = inc_val;
        res.to_mem = 1'b1;
        res.skip   = (inc_val == ZERO_BYTE);
      end
      XMALU_INC_TO_WREG_SKIP_ZERO: begin
        res.value   = inc_val;
        res.to_wreg = 1'b1;
        res.skip    = (inc_val == ZERO_BYTE);
      end
      XMALU_SET_ALL_BITS: begin
        res.value  = ALL_ONES;
        res.to_mem = 1'b1;
      end
      XMALU_SET_BIT: begin
        res.value  = mem_rdata | bit_mask;
        res.to_mem = 1'b1;
      end
      XMALU_SKIP_IF_BIT_SET: begin
        res.value = mem_rdata;
        res.skip  = |(mem_rdata & bit_mask);
      end
      XMALU_SKIP_IF_NONZERO: begin
        // Rewrite keeps read-sensitive registers behaving as on the real core
        res.value  = mem_rdata;
        res.to_mem = 1'b1;
        res.skip   = (mem_rdata != ZERO_BYTE);
      end
      XMALU_SKIP_IF_ZERO: begin
        res.value  = mem_rdata;
        res.to_mem = 1'b1;
        res.skip   = (mem_rdata == ZERO_BYTE);
      end
      XMALU_NIBBLE_EXCHANGE: begin
        res.value  = {mem_rdata[3:0], mem_rdata[7:4]};
        res.to_mem = 1'b1;
      end
      XMALU_NIBBLE_EXCHANGE_TO_WREG: begin
        res.value   = {mem_rdata[3:0], mem_rdata[7:4]};
        res.to_wreg = 1'b1;
      end
      default: begin
        res.value = ZERO_BYTE;
      end
    endcase
  end

  // Full section address driven straight out, no bank register in the path
  assign mem_addr = go ? issue.addr : mem_waddr_r;

  // Memory write-back registered at the end of the execute cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_we_r    <= 1'b0;
      mem_wdata_r <= ZERO_BYTE;
      mem_waddr_r <= '0;
    end else begin
      mem_we_r <= go && res.to_mem;
      if (go && res.to_mem) begin
        mem_wdata_r <= res.value;
        mem_waddr_r <= issue.addr;
      end
    end
  end

  assign mem_we    = mem_we_r;
  assign mem_wdata = mem_wdata_r;

  // Working register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wreg_r <= ZERO_BYTE;
    end else if (go && res.to_wreg) begin
      wreg_r <= res.value;
    end
  end

  // Status flags, only masked fields move
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags_r <= '0;
    end else if (go) begin
      flags_r <= (flags_r & ~res.flag_mask) | (res.flag_val & res.flag_mask);
    end
  end

  // Skip sequencer: a taken skip adds dummy cycles to total three
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= XMALU_ST_IDLE;
      cyc_r   <= '0;
      skip_r  <= 1'b0;
    end else begin
      case (state_r)
        XMALU_ST_IDLE: begin
          skip_r <= go && res.skip;
          if (go && res.skip) begin
            state_r <= XMALU_ST_DUMMY;
            cyc_r   <= CYC_FIRST;
          end
          // Untaken skip stays idle so the next issue follows at once
        end
        XMALU_ST_DUMMY: begin
          skip_r <= 1'b0;
          if (cyc_r == CYC_LAST) begin
            state_r <= XMALU_ST_IDLE;
            cyc_r   <= '0;
          end else begin
            cyc_r <= cyc_r + CYC_FIRST;
          end
        end
        default: begin
          state_r <= XMALU_ST_IDLE;
          cyc_r   <= '0;
          skip_r  <= 1'b0;
        end
      endcase
    end
  end

  assign busy             = (state_r != XMALU_ST_IDLE);
  assign dummy_cycle      = busy;
  assign skip_next        = skip_r;
  assign working_register = wreg_r;
  assign status_flags     = flags_r;

endmodule // xmalu_core

// ===== rtl/xmalu_pkg.sv
// Package for the extended data-memory ALU group: opcodes, flag layout, timing constants.
// Assumes one core clock; data memory addressed with a full section+offset address.
package xmalu_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned BIT_SEL_W   = 3;
  localparam int unsigned SKIP_CYCLES = 3;
  localparam int unsigned CYC_CNT_W   = 2;

  localparam logic [7:0]           ALL_ONES   = 8'hFF;
  localparam logic [7:0]           ZERO_BYTE  = 8'h00;
  localparam logic [7:0]           ONE_BYTE   = 8'h01;
  localparam logic [4:0]           NIB_ONE    = 5'h01;
  localparam logic [CYC_CNT_W-1:0] CYC_FIRST  = 2'h1;
  localparam logic [CYC_CNT_W-1:0] CYC_LAST   = 2'(SKIP_CYCLES - 1);

  // Status flag bit positions
  localparam int unsigned FLG_C  = 0;
  localparam int unsigned FLG_AC = 1;
  localparam int unsigned FLG_Z  = 2;
  localparam int unsigned FLG_OV = 3;
  localparam int unsigned FLG_SC = 4;
  localparam int unsigned FLG_CZ = 5;
  localparam int unsigned FLG_W  = 6;

  typedef enum logic [4:0] {
    XMALU_NOP                            = 5'h00,
    XMALU_ROTATE_LEFT_MEM                = 5'h01,
    XMALU_ROTATE_LEFT_TO_WREG            = 5'h02,
    XMALU_ROTATE_LEFT_THRU_CARRY         = 5'h03,
    XMALU_ROTATE_LEFT_THRU_CARRY_TO_WREG = 5'h04,
    XMALU_ROTATE_RIGHT_MEM               = 5'h05,
    XMALU_ROTATE_RIGHT_TO_WREG           = 5'h06,
    XMALU_ROTATE_RIGHT_THRU_CARRY        = 5'h07,
    XMALU_ROTATE_RIGHT_THRU_CARRY_TO_WREG= 5'h08,
    XMALU_SUBTRACT_BORROW_TO_WREG        = 5'h09,
    XMALU_SUBTRACT_BORROW_TO_MEM         = 5'h0A,
    XMALU_SUBTRACT_TO_WREG               = 5'h0B,
    XMALU_SUBTRACT_TO_MEM                = 5'h0C,
    XMALU_DEC_SKIP_ZERO                  = 5'h0D,
    XMALU_DEC_TO_WREG_SKIP_ZERO          = 5'h0E,
    XMALU_INC_SKIP_ZERO                  = 5'h0F,
    XMALU_INC_TO_WREG_SKIP_ZERO          = 5'h10,
    XMALU_SET_ALL_BITS                   = 5'h11,
    XMALU_SET_BIT                        = 5'h12,
    XMALU_SKIP_IF_BIT_SET                = 5'h13,
    XMALU_SKIP_IF_NONZERO                = 5'h14,
    XMALU_SKIP_IF_ZERO                   = 5'h15,
    XMALU_NIBBLE_EXCHANGE                = 5'h16,
    XMALU_NIBBLE_EXCHANGE_TO_WREG        = 5'h17
  } xmalu_op_e;

  typedef enum logic [1:0] {
    XMALU_ST_IDLE  = 2'b00,
    XMALU_ST_DUMMY = 2'b01
  } xmalu_state_e;

  // One issued instruction
  typedef struct packed {
    xmalu_op_e              op;
    logic [ADDR_W-1:0]      addr;
    logic [BIT_SEL_W-1:0]   bit_sel;
  } xmalu_instr_s;

  // Combinational result of one operation
  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic              to_mem;
    logic              to_wreg;
    logic              skip;
    logic [FLG_W-1:0]  flag_mask;
    logic [FLG_W-1:0]  flag_val;
  } xmalu_result_s;

endpackage : xmalu_pkg

// ===== rtl/xmalu_subtract.sv
// Subtractor with full arithmetic flag set for the extended memory ALU group.
// Assumes operands already selected; purely combinational.
`timescale 1ns/10ps
module xmalu_subtract
  import xmalu_pkg::*;
(
  // Operands
  input  wire logic [DATA_W-1:0] minuend,
  input  wire logic [DATA_W-1:0] subtrahend,
  input  wire logic              borrow_in,
  input  wire logic              zero_in,
  input  wire logic              chain,
  // Result
  output logic      [DATA_W-1:0] diff,
  output logic      [FLG_W-1:0]  flags
);

  logic [DATA_W:0] wide;
  logic [4:0]      low;
  logic            ovf;
  logic            zro;

  always_comb begin
    wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
    low  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
    diff = wide[DATA_W-1:0];
    ovf  = (minuend[7] != subtrahend[7]) && (diff[7] != minuend[7]);
    zro  = (diff == ZERO_BYTE);
    flags            = '0;
    flags[FLG_C]     = ~wide[DATA_W];      // Borrow clears carry
    flags[FLG_AC]    = ~low[4];
    flags[FLG_Z]     = zro;
    flags[FLG_OV]    = ovf;
    flags[FLG_SC]    = ovf ^ diff[7];
    // Chained zero holds only if the earlier byte was zero too
    flags[FLG_CZ]    = chain ? (zro & zero_in) : zro;
  end

endmodule // xmalu_subtract

// ===== verif/tb_top.sv
// Self-checking bench for the extended memory ALU execute stage.
// Assumes the bench owns data memory and answers reads combinationally.
`timescale 1ns/10ps
module tb_top;
  import xmalu_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] wreg;
    logic [FLG_W-1:0]  flg;
    logic              we;
    logic [DATA_W-1:0] wd;
    logic              skip;
  } xmalu_exp_s;

  localparam logic [31:0] EDGE_VALS = 32'h80FF0100;

  logic              clk;
  logic              resetn;
  logic              issue_valid;
  xmalu_instr_s      issue;
  logic              busy;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_rdata;
  logic              mem_we;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] working_register;
  logic [FLG_W-1:0]  status_flags;
  logic              skip_next;
  logic              dummy_cycle;
  logic [DATA_W-1:0] mem_img [4096];
  logic [ADDR_W-1:0] wr_a;
  logic [ADDR_W-1:0] last_a;
  logic [DATA_W-1:0] mw;
  logic [FLG_W-1:0]  mf;
  logic              took;
  int                error_cnt = 0;
  int                n_tests = 0;
  xmalu_exp_s        exp_q[$];

  xmalu_core i_dut (
    .clk(clk), .resetn(resetn), .issue_valid(issue_valid), .issue(issue), .busy(busy),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .working_register(working_register), .status_flags(status_flags),
    .skip_next(skip_next), .dummy_cycle(dummy_cycle)
  );

  assign mem_rdata = mem_img[mem_addr];

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Writes land at the address captured at issue, not the live read address
  always @(posedge clk) begin
    took <= resetn && issue_valid && !busy;
    if (issue_valid && !busy)
      wr_a <= issue.addr;
    if (mem_we === 1'b1)
      mem_img[wr_a] <= mem_wdata;
  end

  task automatic tally(input logic ok, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, got, exp);
  endtask
  task automatic cmp_flags(input logic [FLG_W-1:0] got, input logic [FLG_W-1:0] exp);
    tally(got === exp, 8'(got), 8'(exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    tally(got === exp, 8'(got), 8'(exp));
  endtask

  always @(negedge clk) begin
    if (took === 1'b1) begin
      xmalu_exp_s e;
      e = exp_q.pop_front();
      cmp_byte(working_register, e.wreg);
      cmp_flags(status_flags, e.flg);
      cmp_bit(mem_we, e.we);
      if (e.we)
        cmp_byte(mem_wdata, e.wd);
      cmp_bit(skip_next, e.skip);
    end
  end

  // Offers refused junk while busy, then issues and notes the expected result
  task automatic drive(input xmalu_op_e op, input logic [ADDR_W-1:0] a,
                       input logic [BIT_SEL_W-1:0] b);
    xmalu_exp_s e;
    logic [7:0] m;
    logic [7:0] v;
    logic [8:0] d;
    logic [4:0] l;
    logic       c;
    logic       bi;
    int         n;
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 4) begin
      issue = {XMALU_ROTATE_LEFT_TO_WREG, ~a, b};
      n++;
      @(negedge clk);
    end
    m = mem_img[a];
    c = mf[FLG_C];
    e = {mw, mf, 1'b0, 8'h00, 1'b0};
    v = m;
    case (op)
      5'h01, 5'h02: v = {m[6:0], m[7]};
      5'h03, 5'h04: begin
        v = {m[6:0], c};
        e.flg[FLG_C] = m[7];
      end
      5'h05, 5'h06: v = {m[0], m[7:1]};
      5'h07, 5'h08: begin
        v = {c, m[7:1]};
        e.flg[FLG_C] = m[0];
      end
      5'h09, 5'h0A, 5'h0B, 5'h0C: begin
        bi = (op < 5'h0B) && !c;
        d = {1'b0, mw} - {1'b0, m} - 9'(bi);
        l = {1'b0, mw[3:0]} - {1'b0, m[3:0]} - 5'(bi);
        v = d[7:0];
        e.flg[FLG_C] = !d[8];
        e.flg[FLG_AC] = !l[4];
        e.flg[FLG_Z] = (v == 8'h00);
        e.flg[FLG_OV] = (mw[7] ^ m[7]) & (mw[7] ^ v[7]);
        e.flg[FLG_SC] = e.flg[FLG_OV] ^ v[7];
        e.flg[FLG_CZ] = e.flg[FLG_Z] & (op > 5'h0A || mf[FLG_Z]);
      end
      5'h0D, 5'h0E: v = m - 8'h01;
      5'h0F, 5'h10: v = m + 8'h01;
      5'h11: v = 8'hFF;
      5'h12: v = m | (8'h01 << b);
      5'h13: e.skip = m[b];
      5'h14: e.skip = (m != 8'h00);
      5'h15: e.skip = (m == 8'h00);
      5'h16, 5'h17: v = {m[3:0], m[7:4]};
      default: ;
    endcase
    if (op inside {[5'h0D:5'h10]})
      e.skip = (v == 8'h00);
    if (op inside {5'h02, 5'h04, 5'h06, 5'h08, 5'h09, 5'h0B, 5'h0E, 5'h10, 5'h17}) begin
      e.wreg = v;
    end else if (op != 5'h00 && op != 5'h13) begin
      e.we = 1'b1;
      e.wd = v;
    end
    mw = e.wreg;
    mf = e.flg;
    issue_valid = 1'b1;
    issue = {op, a, b};
    last_a = a;
    exp_q.push_back(e);
  endtask

  task automatic give_verdict;
    $display("Comparisons: %0d, mismatches: %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    logic [ADDR_W-1:0] a;
    issue_valid = 1'b0;
    issue = '0;
    resetn = 1'b0;
    last_a = '0;
    mw = '0;
    mf = '0;
    void'($urandom(99721));
    for (int i = 0; i < 4096; i++)
      mem_img[i] = 8'($urandom);
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    cmp_byte(working_register, 8'h00);
    cmp_flags(status_flags, 6'h00);
    // Every opcode against zero, one, all-ones and sign-only bytes, back to back
    for (int k = 0; k < 4; k++)
      for (int o = 0; o < 24; o++) begin
        a = {k[1:0], o[4:0], 5'h15};
        mem_img[a] = EDGE_VALS[8*k +: 8];
        drive(xmalu_op_e'(o[4:0]), a, 3'(k * 3));
      end
    // Random traffic over all sections in two rounds, each followed by a reset
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 200; i++) begin
        a = 12'($urandom);
        if (a == last_a)
          a = ~a;
        drive(xmalu_op_e'(5'($urandom_range(23, 0))), a, 3'($urandom));
      end
      @(negedge clk);
      issue_valid = 1'b0;
      repeat (4) @(negedge clk);
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      mw = '0;
      mf = '0;
      cmp_byte(working_register, 8'h00);
      cmp_flags(status_flags, 6'h00);
      cmp_bit(busy, 1'b0);
    end
    give_verdict();
  end

  // About six hundred cycles are expected; ten thousand means a hang
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule // tb_top

bind xmalu_core xmalu_core_asserts i_chk (
  .clk(clk), .resetn(resetn), .issue_valid(issue_valid), .issue(issue), .busy(busy),
  .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata),
  .working_register(working_register), .status_flags(status_flags),
  .skip_next(skip_next), .dummy_cycle(dummy_cycle)
);

// ===== verif/xmalu_core_asserts.sv
// Concurrent checks for the extended memory ALU execute stage.
// Assumes a bind onto xmalu_core; one clock domain.
`timescale 1ns/10ps
module xmalu_core_asserts
  import xmalu_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // Issue
  input wire logic              issue_valid,
  input wire xmalu_instr_s      issue,
  input wire logic              busy,
  // Memory
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic              mem_we,
  input wire logic [DATA_W-1:0] mem_wdata,
  // State and sequencing
  input wire logic [DATA_W-1:0] working_register,
  input wire logic [FLG_W-1:0]  status_flags,
  input wire logic              skip_next,
  input wire logic              dummy_cycle
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  logic              tk;
  logic [DATA_W-1:0] rd_r;
  logic [DATA_W-1:0] wreg_r;

  assign tk = issue_valid && !busy;

  // Operands as they stood in the issue cycle
  always_ff @(posedge clk) begin
    rd_r   <= mem_rdata;
    wreg_r <= working_register;
  end

  sequence take_op(logic [4:0] code);
    tk && issue.op == code;
  endsequence

  sequence dummy_pair;
    busy && dummy_cycle ##1 busy && dummy_cycle ##1 !busy;
  endsequence

  chk_skip_three:
    assert property (skip_next |-> dummy_pair)
    else $error("taken skip not followed by two dummy cycles");
  chk_no_dummy:
    assert property (tk ##1 !skip_next |-> !busy)
    else $error("dummy cycle without a taken skip");
  chk_we_cause:
    assert property (mem_we |-> $past(tk))
    else $error("memory write without an accepted instruction");
  chk_addr_direct:
    assert property (tk |-> mem_addr == issue.addr)
    else $error("read address differs from issued address");
  chk_busy_refuse:
    assert property (busy |=> !mem_we)
    else $error("instruction accepted during a dummy cycle");
  chk_set_all:
    assert property (take_op(5'h11) |=> mem_we && mem_wdata == ALL_ONES && $stable(status_flags))
    else $error("set byte did not write all ones");
  chk_rot_left:
    assert property (take_op(5'h01) |=> mem_we && mem_wdata == {rd_r[6:0], rd_r[7]})
    else $error("rotate left result wrong");
  chk_sub_carry:
    assert property (take_op(5'h0B) |=> status_flags[FLG_C] == (wreg_r >= rd_r)
      && working_register == wreg_r - rd_r)
    else $error("subtract result or carry wrong");
endmodule // xmalu_core_asserts
